// ---- hw/uies_defines.svh ----
// register offsets, field positions, reset values and timing counts of the channel interrupt block
`ifndef UIES_DEFINES_SVH
`define UIES_DEFINES_SVH

// byte addresses, register index times four
`define UIES_IDX_HOLDING 3'h0
`define UIES_IDX_MASK 3'h1
`define UIES_IDX_STATUS 3'h2
`define UIES_IDX_ENH 3'h3
`define UIES_IDX_LINE 3'h5
`define UIES_IDX_MODEM 3'h6
`define UIES_ADDR_WIDTH 8

// interrupt_mask fields
`define UIES_MASK_RXDATA 0
`define UIES_MASK_TX_READY_EVENT 1
`define UIES_MASK_LINE 2
`define UIES_MASK_MODEM 3
`define UIES_MASK_SLEEP 4
`define UIES_MASK_XOFF 5
`define UIES_MASK_RTS 6
`define UIES_MASK_CTS 7
`define UIES_MASK_RESET 8'h00

// fifo_control fields
`define UIES_FCR_ENABLE 0
`define UIES_FCR_RXRST 1
`define UIES_FCR_TXRST 2

// enhanced_feature_control fields
`define UIES_ENH_ENABLE 4
`define UIES_ENH_AUTORTS 6
`define UIES_ENH_AUTOCTS 7
`define UIES_ENH_RESET 8'h00

// trigger levels, receive then transmit, selected by two bits each
`define UIES_RX_TRIG0 6'h08
`define UIES_RX_TRIG1 6'h10
`define UIES_RX_TRIG2 6'h18
`define UIES_RX_TRIG3 6'h1e
`define UIES_TX_TRIG0 6'h10
`define UIES_TX_TRIG1 6'h08
`define UIES_TX_TRIG2 6'h18
`define UIES_TX_TRIG3 6'h1e

// receive time-out: four characters plus twelve bits
`define UIES_TO_CHARS 7'h04
`define UIES_TO_BITS 7'h0c

// status codes on bits 5:0, bit 0 low means pending
`define UIES_CODE_LINE 6'h06
`define UIES_CODE_TOUT 6'h0c
`define UIES_CODE_RXDATA 6'h04
`define UIES_CODE_TX_READY_EVENT 6'h02
`define UIES_CODE_MODEM 6'h00
`define UIES_CODE_XOFF 6'h10
`define UIES_CODE_FLOW 6'h20
`define UIES_CODE_NONE 6'h01

`endif

// ---- hw/uies_pkg.sv ----
// types of the channel interrupt block
package uies_pkg;

	// interrupt sources in priority order, one-hot
	typedef enum logic [7:0] {
		UIES_SRC_NONE = 8'h01,
		UIES_SRC_LINE = 8'h02,
		UIES_SRC_TOUT = 8'h04,
		UIES_SRC_RXDATA = 8'h08,
		UIES_SRC_TX_READY_EVENT = 8'h10,
		UIES_SRC_MODEM = 8'h20,
		UIES_SRC_XOFF = 8'h40,
		UIES_SRC_FLOW = 8'h80
	} uies_src_t;

endpackage

// ---- hw/uies_top.sv ----
// channel interrupt masking, priority, status and clear-on-access logic behind an apb slave
//
// How it works
// - rx data interrupt tracks trigger level crossing
// - data-ready bit follows receive fifo non-empty
// - line status reports holding and all-empty
// - line status overrun, head errors, fifo error
// - mask bit0 enables receive data interrupt
// - mask bit1 enables tx ready, immediate
// - mask bit2 enables line error interrupt
// - mask bit3 enables modem delta interrupt
// - sleep enable needs enhanced enable
// - xoff/special interrupt needs enhanced enable
// - rts rising edge interrupt under auto rts
// - cts rising edge interrupt under auto cts
// - status returns highest pending, holds reported
// - time-out after four chars twelve bits
// - tx ready cleared by status read, push
// - line status read clears line interrupt
// - rx data interrupt persists until below trigger
// - modem read clears modem and flow
// - xoff cleared by status read or xon
// - special cleared by status read, next char
// - bit0 low when pending, code bits 5:1
// - top two status bits show fifo enable
`timescale 1ns/100ps
`include "uies_defines.svh"
`default_nettype none

module uies_top
	import uies_pkg::*;
(
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic CE,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [`UIES_ADDR_WIDTH-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// channel sources, same clock
	input wire logic [5:0] RX_LEVEL,
	input wire logic [5:0] TX_LEVEL,
	input wire logic TSR_EMPTY,
	input wire logic RX_CHAR_IN,
	input wire logic [7:0] RX_DATA,
	input wire logic [2:0] RX_HOLD_ERR,
	input wire logic RX_FIFO_ERR,
	input wire logic OVERRUN,
	input wire logic [7:0] MODEM_STATUS,
	input wire logic XOFF_DET,
	input wire logic XON_DET,
	input wire logic SPECIAL_DET,
	input wire logic RTS_LEVEL,
	input wire logic BIT_TICK,
	input wire logic [3:0] CHAR_BITS,
	// cts pin, asynchronous
	input wire logic CTS_PIN,
	// to the channel
	output logic RX_POP,
	output logic TX_PUSH,
	output logic [7:0] TX_DATA,
	output logic MODEM_READ,
	output logic RX_FIFO_RST,
	output logic TX_FIFO_RST,
	output logic FIFO_EN,
	output logic [5:0] RX_TRIG,
	output logic [5:0] TX_TRIG,
	output logic SLEEP_EN,
	output logic INT_OUT
);

	logic [7:0] interrupt_mask; // software mask
	logic [7:0] enh_ctrl; // enhanced feature control
	logic [1:0] rx_sel; // receive trigger select
	logic [1:0] tx_sel; // transmit trigger select
	logic overrun_flag; // sticky overrun
	logic line_flag; // sticky line interrupt
	logic tx_ready_event_flag; // sticky transmit ready
	logic tout_flag; // receive time-out pending
	logic xoff_flag; // xoff received
	logic special_flag; // special character received
	logic rts_flag; // rts rose
	logic cts_flag; // cts rose
	logic [6:0] tout_cnt; // bit times since last activity
	logic cts_meta; // first synchroniser stage
	logic cts_sync; // second synchroniser stage
	logic cts_prev; // for edge detect
	logic rts_prev; // for edge detect
	logic [5:0] tx_level_prev; // last transmit fill
	logic [2:0] hold_err_prev; // last head error set
	uies_src_t held_src; // source reported by last status read
	uies_src_t top_src; // current highest pending
	uies_src_t shown_src; // what a status read returns

	// decoded bus events, all at the completing edge
	logic done;
	logic [2:0] idx;
	logic mapped;
	logic rd_status;
	logic rd_line;
	logic rd_modem;
	logic rd_rx;
	logic wr_tx;
	logic wr_mask;
	logic wr_fcr;
	logic enh_on;
	logic fifo_en;
	logic rx_has;
	logic rx_data_pend;
	logic line_pend;
	logic modem_pend;
	logic xoff_pend;
	logic flow_pend;
	logic any_pend;
	logic [6:0] tout_limit;
	logic [5:0] code;
	logic [7:0] status_val;
	logic [7:0] line_val;
	logic [7:0] next_rd;
	logic [5:0] rx_trig;
	logic [5:0] tx_trig;

	assign done = PSEL & PENABLE & PREADY;
	assign idx = PADDR[4:2];
	assign mapped = (PADDR[1:0] == 2'h0) && (PADDR[`UIES_ADDR_WIDTH-1:5] == '0) && (idx != 3'h4) && (idx != 3'h7);
	assign rd_status = done & ~PWRITE & (idx == `UIES_IDX_STATUS) & mapped;
	assign rd_line = done & ~PWRITE & (idx == `UIES_IDX_LINE) & mapped;
	assign rd_modem = done & ~PWRITE & (idx == `UIES_IDX_MODEM) & mapped;
	assign rd_rx = done & ~PWRITE & (idx == `UIES_IDX_HOLDING) & mapped;
	assign wr_tx = done & PWRITE & (idx == `UIES_IDX_HOLDING) & mapped;
	assign wr_mask = done & PWRITE & (idx == `UIES_IDX_MASK) & mapped;
	assign wr_fcr = done & PWRITE & (idx == `UIES_IDX_STATUS) & mapped;
	assign enh_on = enh_ctrl[`UIES_ENH_ENABLE];
	assign fifo_en = FIFO_EN;
	assign rx_has = (RX_LEVEL != 6'h00);

	// trigger level tables
	always_comb begin
		case (rx_sel)
			2'h0: rx_trig = `UIES_RX_TRIG0;
			2'h1: rx_trig = `UIES_RX_TRIG1;
			2'h2: rx_trig = `UIES_RX_TRIG2;
			default: rx_trig = `UIES_RX_TRIG3;
		endcase
		case (tx_sel)
			2'h0: tx_trig = `UIES_TX_TRIG0;
			2'h1: tx_trig = `UIES_TX_TRIG1;
			2'h2: tx_trig = `UIES_TX_TRIG2;
			default: tx_trig = `UIES_TX_TRIG3;
		endcase
	end

	// level-based sources, masked
	assign rx_data_pend = interrupt_mask[`UIES_MASK_RXDATA] & (fifo_en ? (RX_LEVEL >= RX_TRIG) : rx_has);
	assign line_pend = interrupt_mask[`UIES_MASK_LINE] & line_flag;
	assign modem_pend = interrupt_mask[`UIES_MASK_MODEM] & (MODEM_STATUS[3:0] != 4'h0);
	assign xoff_pend = enh_on & interrupt_mask[`UIES_MASK_XOFF] & (xoff_flag | special_flag);
	assign flow_pend = enh_on & ((interrupt_mask[`UIES_MASK_RTS] & rts_flag) | (interrupt_mask[`UIES_MASK_CTS] & cts_flag));
	assign tout_limit = 7'((`UIES_TO_CHARS * {3'h0, CHAR_BITS}) + `UIES_TO_BITS);

	// priority encoder, highest first
	always_comb begin
		if (line_pend) begin
			top_src = UIES_SRC_LINE;
		end else if (interrupt_mask[`UIES_MASK_RXDATA] & tout_flag) begin
			top_src = UIES_SRC_TOUT;
		end else if (rx_data_pend) begin
			top_src = UIES_SRC_RXDATA;
		end else if (interrupt_mask[`UIES_MASK_TX_READY_EVENT] & tx_ready_event_flag) begin
			top_src = UIES_SRC_TX_READY_EVENT;
		end else if (modem_pend) begin
			top_src = UIES_SRC_MODEM;
		end else if (xoff_pend) begin
			top_src = UIES_SRC_XOFF;
		end else if (flow_pend) begin
			top_src = UIES_SRC_FLOW;
		end else begin
			top_src = UIES_SRC_NONE;
		end
	end

	// a reported line, time-out, rx data, modem or flow source keeps the status until it is serviced
	always_comb begin
		any_pend = (top_src != UIES_SRC_NONE);
		shown_src = top_src;
		case (held_src)
			UIES_SRC_LINE: if (line_pend) shown_src = held_src;
			UIES_SRC_TOUT: if (interrupt_mask[`UIES_MASK_RXDATA] & tout_flag) shown_src = held_src;
			UIES_SRC_RXDATA: if (rx_data_pend) shown_src = held_src;
			UIES_SRC_MODEM: if (modem_pend) shown_src = held_src;
			UIES_SRC_FLOW: if (flow_pend) shown_src = held_src;
			default: shown_src = top_src;
		endcase
		case (shown_src)
			UIES_SRC_LINE: code = `UIES_CODE_LINE;
			UIES_SRC_TOUT: code = `UIES_CODE_TOUT;
			UIES_SRC_RXDATA: code = `UIES_CODE_RXDATA;
			UIES_SRC_TX_READY_EVENT: code = `UIES_CODE_TX_READY_EVENT;
			UIES_SRC_MODEM: code = `UIES_CODE_MODEM;
			UIES_SRC_XOFF: code = `UIES_CODE_XOFF;
			UIES_SRC_FLOW: code = `UIES_CODE_FLOW;
			default: code = `UIES_CODE_NONE;
		endcase
		status_val = {fifo_en, fifo_en, code};
	end

	// line status view
	assign line_val = {RX_FIFO_ERR & rx_has, (TX_LEVEL == 6'h00) & TSR_EMPTY, TX_LEVEL == 6'h00,
		RX_HOLD_ERR & {3{rx_has}}, overrun_flag, rx_has};

	// read data mux
	always_comb begin
		if (idx == `UIES_IDX_HOLDING) begin
			next_rd = RX_DATA;
		end else if (idx == `UIES_IDX_MASK) begin
			next_rd = interrupt_mask;
		end else if (idx == `UIES_IDX_STATUS) begin
			next_rd = status_val;
		end else if (idx == `UIES_IDX_ENH) begin
			next_rd = enh_ctrl;
		end else if (idx == `UIES_IDX_LINE) begin
			next_rd = line_val;
		end else if (idx == `UIES_IDX_MODEM) begin
			next_rd = MODEM_STATUS;
		end else begin
			next_rd = 8'h00;
		end
	end

	// apb handshake, one wait state
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0;
			PSLVERR <= 1'b0;
		end else if (CE) begin
			PREADY <= PSEL & PENABLE & ~PREADY;
			PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
			PRDATA <= (PSEL & PENABLE & ~PREADY & ~PWRITE & mapped) ? {24'h0, next_rd} : 32'h0;
		end
	end

	// control registers
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			interrupt_mask <= `UIES_MASK_RESET;
			enh_ctrl <= `UIES_ENH_RESET;
			FIFO_EN <= 1'b0;
			rx_sel <= 2'h0;
			tx_sel <= 2'h0;
		end else if (CE) begin
			if (wr_mask) begin
				interrupt_mask <= PWDATA[7:0];
			end
			if (done & PWRITE & mapped & (idx == `UIES_IDX_ENH)) begin
				enh_ctrl <= PWDATA[7:0];
			end
			if (wr_fcr) begin
				FIFO_EN <= PWDATA[`UIES_FCR_ENABLE];
				// other fields only take with the enable bit set
				if (PWDATA[`UIES_FCR_ENABLE]) begin
					rx_sel <= PWDATA[7:6];
					if (enh_on) begin
						tx_sel <= PWDATA[5:4];
					end
				end
			end
		end
	end

	// registered channel controls and strobes
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			RX_POP <= 1'b0;
			TX_PUSH <= 1'b0;
			TX_DATA <= 8'h00;
			MODEM_READ <= 1'b0;
			RX_FIFO_RST <= 1'b0;
			TX_FIFO_RST <= 1'b0;
			RX_TRIG <= `UIES_RX_TRIG0;
			TX_TRIG <= `UIES_TX_TRIG0;
			SLEEP_EN <= 1'b0;
			INT_OUT <= 1'b0;
		end else if (CE) begin
			RX_POP <= rd_rx;
			TX_PUSH <= wr_tx;
			if (wr_tx) begin
				TX_DATA <= PWDATA[7:0];
			end
			MODEM_READ <= rd_modem;
			RX_FIFO_RST <= wr_fcr & PWDATA[`UIES_FCR_ENABLE] & PWDATA[`UIES_FCR_RXRST];
			TX_FIFO_RST <= wr_fcr & PWDATA[`UIES_FCR_ENABLE] & PWDATA[`UIES_FCR_TXRST];
			RX_TRIG <= rx_trig;
			TX_TRIG <= tx_trig;
			SLEEP_EN <= enh_on & interrupt_mask[`UIES_MASK_SLEEP];
			INT_OUT <= any_pend;
		end
	end

	// cts synchroniser and edge history
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			cts_meta <= 1'b0;
			cts_sync <= 1'b0;
			cts_prev <= 1'b0;
			rts_prev <= 1'b0;
			tx_level_prev <= 6'h00;
			hold_err_prev <= 3'h0;
		end else if (CE) begin
			cts_meta <= CTS_PIN;
			cts_sync <= cts_meta;
			cts_prev <= cts_sync;
			rts_prev <= RTS_LEVEL;
			tx_level_prev <= TX_LEVEL;
			hold_err_prev <= RX_HOLD_ERR & {3{rx_has}};
		end
	end

	// line error flags, set wins over the read clear
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			overrun_flag <= 1'b0;
			line_flag <= 1'b0;
		end else if (CE) begin
			if (OVERRUN) begin
				overrun_flag <= 1'b1;
			end else if (rd_line) begin
				overrun_flag <= 1'b0;
			end
			// overrun at once, head errors when they reach the head
			if (OVERRUN | ((RX_HOLD_ERR & {3{rx_has}} & ~hold_err_prev) != 3'h0)) begin
				line_flag <= 1'b1;
			end else if (rd_line) begin
				line_flag <= 1'b0;
			end
		end
	end

	// transmit ready flag
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			tx_ready_event_flag <= 1'b0;
		end else if (CE) begin
			if ((fifo_en & (TX_LEVEL < TX_TRIG) & (tx_level_prev >= TX_TRIG))
				| ((TX_LEVEL == 6'h00) & (tx_level_prev != 6'h00))) begin
				tx_ready_event_flag <= 1'b1;
			end else if (wr_mask & PWDATA[`UIES_MASK_TX_READY_EVENT] & ~interrupt_mask[`UIES_MASK_TX_READY_EVENT]
				& (TX_LEVEL == 6'h00)) begin
				tx_ready_event_flag <= 1'b1;
			end else if (wr_tx | (rd_status & (shown_src == UIES_SRC_TX_READY_EVENT))) begin
				tx_ready_event_flag <= 1'b0;
			end
		end
	end

	// receive time-out timer, restarted by any receive activity
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			tout_cnt <= 7'h00;
			tout_flag <= 1'b0;
		end else if (CE) begin
			if (!fifo_en || !rx_has || RX_CHAR_IN || rd_rx) begin
				tout_cnt <= 7'h00;
			end else if (BIT_TICK && (tout_cnt < tout_limit)) begin
				tout_cnt <= tout_cnt + 7'h01;
			end
			if (fifo_en && rx_has && BIT_TICK && (tout_cnt + 7'h01 == tout_limit) && !RX_CHAR_IN && !rd_rx) begin
				tout_flag <= 1'b1;
			end else if (rd_rx) begin
				tout_flag <= 1'b0;
			end
		end
	end

	// software flow flags
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			xoff_flag <= 1'b0;
			special_flag <= 1'b0;
		end else if (CE) begin
			if (XOFF_DET) begin
				xoff_flag <= 1'b1;
			end else if (rd_status | XON_DET) begin
				xoff_flag <= 1'b0;
			end
			if (SPECIAL_DET) begin
				special_flag <= 1'b1;
			end else if (rd_status | RX_CHAR_IN) begin
				special_flag <= 1'b0;
			end
		end
	end

	// hardware flow transition flags
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			rts_flag <= 1'b0;
			cts_flag <= 1'b0;
		end else if (CE) begin
			if (enh_ctrl[`UIES_ENH_AUTORTS] & RTS_LEVEL & ~rts_prev) begin
				rts_flag <= 1'b1;
			end else if (rd_modem) begin
				rts_flag <= 1'b0;
			end
			if (enh_ctrl[`UIES_ENH_AUTOCTS] & cts_sync & ~cts_prev) begin
				cts_flag <= 1'b1;
			end else if (rd_modem) begin
				cts_flag <= 1'b0;
			end
		end
	end

	// remember the reported source until it is serviced
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			held_src <= UIES_SRC_NONE;
		end else if (CE) begin
			if (rd_status) begin
				held_src <= shown_src;
			end else if (shown_src != held_src) begin
				held_src <= UIES_SRC_NONE;
			end
		end
	end

endmodule // uies_top

`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench of the channel interrupt block over apb
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic CLOCK = 0, NRST = 0, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA;
	logic PREADY, PSLVERR, last_err;
	logic [5:0] RX_LEVEL, TX_LEVEL, RX_TRIG, TX_TRIG;
	logic RX_CHAR_IN = 0, OVERRUN = 0, msr_add = 0, TSR_EMPTY = 1;
	logic [7:0] RX_DATA = 8'h00, MODEM_STATUS, TX_DATA;
	logic [2:0] RX_HOLD_ERR = 3'h0;
	logic RX_FIFO_ERR = 0, XOFF_DET = 0, XON_DET = 0, SPECIAL_DET = 0, RTS_LEVEL = 0, BIT_TICK = 0, CTS_PIN = 0;
	logic [3:0] CHAR_BITS = 4'ha;
	logic RX_POP, TX_PUSH, MODEM_READ, RX_FIFO_RST, TX_FIFO_RST, FIFO_EN, SLEEP_EN, INT_OUT;
	int num_errors = 0, compares = 0;
	uies_top u_dut (.CLOCK, .NRST, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
		.RX_LEVEL, .TX_LEVEL, .TSR_EMPTY, .RX_CHAR_IN, .RX_DATA, .RX_HOLD_ERR, .RX_FIFO_ERR, .OVERRUN,
		.MODEM_STATUS, .XOFF_DET, .XON_DET, .SPECIAL_DET, .RTS_LEVEL, .BIT_TICK, .CHAR_BITS, .CTS_PIN,
		.RX_POP, .TX_PUSH, .TX_DATA, .MODEM_READ, .RX_FIFO_RST, .TX_FIFO_RST, .FIFO_EN, .RX_TRIG, .TX_TRIG,
		.SLEEP_EN, .INT_OUT);
	uies_chan_model u_chan (.CLOCK, .NRST, .rx_add(RX_CHAR_IN), .msr_add, .RX_POP, .TX_PUSH, .MODEM_READ,
		.RX_LEVEL, .TX_LEVEL, .MODEM_STATUS);
	// 100 MHz clock
	initial begin
		forever #5 CLOCK = ~CLOCK;
	end
	// verdict and end of run
	task print_verdict;
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// one comparison, four-state
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// apb transfer: setup, access held until ready, bounded wait
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge CLOCK);
		PSEL <= 1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1;
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		// a missing ready counts once; the run goes on to the closing report
		if (n >= 20) begin
			num_errors++;
			$display("[ERR] pready exp 1 got %b", PREADY);
		end
		q = PRDATA;
		last_err = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		chk(nm, e, q);
	endtask
	// interrupt line waited for under a bound, then compared
	task waitint(input logic e);
		int n;
		n = 0;
		while (INT_OUT !== e && n < 20) begin
			@(posedge CLOCK);
			n++;
		end
		chk("int_out", {31'h0, e}, {31'h0, INT_OUT});
	endtask
	// one-cycle pulses of channel events
	task addrx(input int k);
		repeat (k) begin
			@(posedge CLOCK);
			RX_CHAR_IN <= 1;
			@(posedge CLOCK);
			RX_CHAR_IN <= 0;
		end
	endtask
	// k selects overrun, xoff, xon or special character
	task pulse_evt(input int k);
		@(posedge CLOCK);
		{SPECIAL_DET, XON_DET, XOFF_DET, OVERRUN} <= 4'(1 << k);
		@(posedge CLOCK);
		{SPECIAL_DET, XON_DET, XOFF_DET, OVERRUN} <= 4'h0;
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge CLOCK);
		NRST <= 1;
		@(posedge CLOCK);
		rdc(8'h04, 32'h00, "mask_rst");
		rdc(8'h08, 32'h01, "status_rst");
		wr(8'h04, 32'hff);
		rdc(8'h04, 32'hff, "mask_rw");
		rdc(8'h10, 32'h00, "unmapped");
		chk("pslverr", 32'h1, {31'h0, last_err});
		wr(8'h04, 32'h00);
		// fifo enable, trigger 16 and both fifo reset pulses
		wr(8'h08, 32'h47);
		@(negedge CLOCK);
		chk("fifo_rst", 32'h3, {30'h0, RX_FIFO_RST, TX_FIFO_RST});
		repeat (2) @(posedge CLOCK);
		chk("rx_trig", 32'h10, {26'h0, RX_TRIG});
		addrx(16);
		waitint(1'b0);
		rdc(8'h14, 32'h61, "line_poll");
		wr(8'h04, 32'h01);
		waitint(1'b1);
		rdc(8'h08, 32'hc4, "status_rx");
		rdc(8'h00, 32'h00, "rx_hold");
		waitint(1'b0);
		rdc(8'h08, 32'hc1, "status_none");
		addrx(1);
		pulse_evt(0);
		wr(8'h04, 32'h05);
		waitint(1'b1);
		rdc(8'h08, 32'hc6, "status_line");
		rdc(8'h14, 32'h63, "line_ovr");
		rdc(8'h08, 32'hc4, "status_after");
		wr(8'h04, 32'h08);
		@(posedge CLOCK);
		msr_add <= 1;
		@(posedge CLOCK);
		msr_add <= 0;
		waitint(1'b1);
		rdc(8'h08, 32'hc0, "status_msr");
		rdc(8'h18, 32'h01, "modem");
		waitint(1'b0);
		wr(8'h04, 32'h02);
		waitint(1'b1);
		rdc(8'h08, 32'hc2, "status_tx");
		waitint(1'b0);
		wr(8'h04, 32'h00);
		wr(8'h04, 32'h02);
		waitint(1'b1);
		wr(8'h00, 32'h55);
		waitint(1'b0);
		// framing error on the character at the holding position
		wr(8'h04, 32'h04);
		RX_HOLD_ERR <= 3'h2;
		waitint(1'b1);
		rdc(8'h14, 32'h09, "line_err");
		RX_HOLD_ERR <= 3'h0;
		waitint(1'b0);
		// enhanced functions: sleep, xoff and special character
		wr(8'h0c, 32'h10);
		wr(8'h04, 32'h30);
		repeat (2) @(posedge CLOCK);
		chk("sleep_en", 32'h1, {31'h0, SLEEP_EN});
		pulse_evt(1);
		waitint(1'b1);
		rdc(8'h08, 32'hd0, "status_xoff");
		waitint(1'b0);
		pulse_evt(1);
		waitint(1'b1);
		pulse_evt(2);
		waitint(1'b0);
		pulse_evt(3);
		waitint(1'b1);
		addrx(1);
		waitint(1'b0);
		// hardware flow transitions, cleared by a modem read
		wr(8'h0c, 32'hd0);
		wr(8'h04, 32'hc0);
		RTS_LEVEL <= 1;
		waitint(1'b1);
		rdc(8'h08, 32'he0, "status_flow");
		rdc(8'h18, 32'h00, "modem_rts");
		waitint(1'b0);
		CTS_PIN <= 1;
		waitint(1'b1);
		rdc(8'h18, 32'h00, "modem_cts");
		waitint(1'b0);
		// receive time-out: 4*10+12 bit ticks with no activity
		wr(8'h04, 32'h01);
		BIT_TICK <= 1;
		repeat (60) @(posedge CLOCK);
		BIT_TICK <= 0;
		rdc(8'h08, 32'hcc, "status_tout");
		rdc(8'h00, 32'h00, "rx_hold2");
		rdc(8'h08, 32'hc4, "status_rx2");
		NRST <= 0;
		repeat (2) @(posedge CLOCK);
		NRST <= 1;
		@(posedge CLOCK);
		rdc(8'h04, 32'h00, "mask_rst2");
		print_verdict();
	end
endmodule // tb_top
bind uies_top uies_top_sva u_sva (.CLOCK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
	.PSLVERR, .RX_LEVEL, .RX_POP, .TX_PUSH, .TX_DATA, .MODEM_READ, .FIFO_EN, .RX_TRIG, .TX_TRIG, .INT_OUT);
`default_nettype wire

// ---- testbench/uies_chan_model.sv ----
// behavioural channel: receive fill, transmit fill and modem deltas
`timescale 1ns/100ps
`default_nettype none
module uies_chan_model (
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic rx_add,
	input wire logic msr_add,
	input wire logic RX_POP,
	input wire logic TX_PUSH,
	input wire logic MODEM_READ,
	output logic [5:0] RX_LEVEL,
	output logic [5:0] TX_LEVEL,
	output logic [7:0] MODEM_STATUS
);
	// fifo fills; transmit never drains so a push keeps it non-empty
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			RX_LEVEL <= 6'h00;
			TX_LEVEL <= 6'h00;
		end else begin
			RX_LEVEL <= RX_LEVEL + 6'(rx_add) - 6'(RX_POP);
			TX_LEVEL <= TX_LEVEL + 6'(TX_PUSH);
		end
	end
	// delta bit cleared by the read strobe, like a real modem block
	always_ff @(posedge CLOCK) begin
		if (!NRST || MODEM_READ)
			MODEM_STATUS <= 8'h00;
		else if (msr_add)
			MODEM_STATUS <= 8'h01;
	end
endmodule // uies_chan_model
`default_nettype wire

// ---- testbench/uies_top_sva.sv ----
// bus and interrupt checks on the ports of the channel interrupt block
`timescale 1ns/100ps
`include "uies_defines.svh"
`default_nettype none
module uies_top_sva
	import uies_pkg::*;
(
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [`UIES_ADDR_WIDTH-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [5:0] RX_LEVEL,
	input wire logic RX_POP,
	input wire logic TX_PUSH,
	input wire logic [7:0] TX_DATA,
	input wire logic MODEM_READ,
	input wire logic FIFO_EN,
	input wire logic [5:0] RX_TRIG,
	input wire logic [5:0] TX_TRIG,
	input wire logic INT_OUT
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	// completed read without error
	logic rd;
	assign rd = PREADY && !PWRITE && !PSLVERR;
	AST_RESET: assert property ($rose(NRST) |-> !INT_OUT && !FIFO_EN && RX_TRIG == 6'h08 && TX_TRIG == 6'h10)
		else $error("reset values wrong");
	AST_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("ready not after one wait");
	AST_PULSE: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	AST_ERR: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
		else $error("error without ready or with data");
	AST_FIFO: assert property (rd && PADDR == 8'h08 |-> PRDATA[7:6] == {2{FIFO_EN}})
		else $error("status top bits differ from fifo enable");
	AST_POP: assert property (rd && PADDR == 8'h00 |=> RX_POP)
		else $error("no pop after holding read");
	AST_PUSH: assert property (PREADY && PWRITE && PADDR == 8'h00 |=> TX_PUSH && TX_DATA == $past(PWDATA[7:0]))
		else $error("no push after holding write");
	AST_MSR: assert property (rd && PADDR == 8'h18 |=> MODEM_READ)
		else $error("no modem read strobe");
	// pop and modem read strobes only follow a completed access, never spontaneously
	AST_STROBE: assert property (RX_POP || MODEM_READ |-> $past(PREADY))
		else $error("strobe without access");
	// level must be steady for the registered path to settle
	AST_DRDY: assert property (rd && PADDR == 8'h14 && $past(RX_LEVEL, 3) == RX_LEVEL && $past(RX_LEVEL) == RX_LEVEL
		|-> PRDATA[0] == (RX_LEVEL != 6'h00))
		else $error("data ready bit wrong");
	COV_PEND: cover property (rd && PADDR == 8'h08 && !PRDATA[0]);
	COV_ERR: cover property (PSLVERR);
	COV_INT: cover property ($rose(INT_OUT));
endmodule // uies_top_sva
`default_nettype wire
